/* File: hw/papc_top.sv */
// top: apb registers, port lines and dedicated strobe pad control
module papc_top
  import papc_pkg::*;
#(
  parameter int N = 8, // number of port lines
  parameter logic [7:0] AF_OUT_MASK = 8'hff, // lines whose alternate is an output
  parameter logic [7:0] AF_AUTO_MASK = 8'h00, // lines with automatic direction
  parameter logic [7:0] AF_PWM_MASK = 8'h00 // pulse-width output lines
)
(
  input wire logic pclk, // clock, 50 MHz
  input wire logic presetn, // async reset, low
  input wire logic psel, // apb select
  input wire logic penable, // apb enable
  input wire logic pwrite, // apb direction
  input wire logic [PAPC_ADDR_W-1:0] paddr, // apb byte address
  input wire logic [31:0] pwdata, // apb write data
  input wire logic [3:0] pstrb, // apb byte strobes
  output logic [31:0] prdata, // apb read data
  output logic pready, // apb ready
  output logic pslverr, // apb error
  input wire logic [N-1:0] af_dout, // alternate output data per line
  input wire logic [N-1:0] hw_dir, // hardware direction per line
  input wire logic [23:0] bus_addr, // external bus address
  input wire logic [N-1:0] pin_in, // pin levels
  output logic [N-1:0] pin_o, // pin drive values
  output logic [N-1:0] pin_oe_n, // pin enables, low drives
  output logic [N-1:0] af_din, // alternate input data
  output logic [1:0] strobe_edge_select, // read and write strobe edge
  output logic [1:0] strobe_drive_select, // read and write strobe drive
  output logic [1:0] latch_enable_edge_select, // address latch edge
  output logic [1:0] latch_enable_drive_select, // address latch drive
  output logic [7:0] seg_addr_o // segment address port
);
  logic [7:0] pad_r;
  logic [N-1:0] latch_r;
  logic [N-1:0] dir_r;
  logic [N-1:0] afen_r;
  logic seg_en_r;
  logic [31:0] rdata_nxt;
  logic [N-1:0] pin_rd;

  wire setup = psel && !penable;
  wire wr_acc = psel && penable && pwrite;
  wire hit_pad = paddr == PAPC_OFF_PAD;
  wire hit_latch = paddr == PAPC_OFF_LATCH;
  wire hit_dir = paddr == PAPC_OFF_DIR;
  wire hit_afen = paddr == PAPC_OFF_AFEN;
  wire hit_pin = paddr == PAPC_OFF_PIN;
  wire hit_afin = paddr == PAPC_OFF_AFIN;
  wire hit_mode = paddr == PAPC_OFF_MODE;
  wire mapped = hit_pad | hit_latch | hit_dir | hit_afen | hit_pin | hit_afin | hit_mode;
  wire wr_ok = wr_acc && pready && !pslverr;
  wire lo_en = pstrb[0];
  // reserved codes are stored as written; the pad simply holds its last legal setting
  wire [1:0] se_w = pwdata[PAPC_SE_LSB +: 2];
  wire [1:0] sd_w = pwdata[PAPC_SD_LSB +: 2];
  wire [1:0] le_w = pwdata[PAPC_LE_LSB +: 2];
  wire [1:0] ld_w = pwdata[PAPC_LD_LSB +: 2];
  wire se_legal = se_w inside {PAPC_EDGE_FAST, PAPC_EDGE_SLOW};
  wire sd_legal = sd_w inside {PAPC_DRV_HIGH, PAPC_DRV_DYN, PAPC_DRV_LOW};
  wire le_legal = le_w inside {PAPC_EDGE_FAST, PAPC_EDGE_SLOW};
  wire ld_legal = ld_w inside {PAPC_DRV_HIGH, PAPC_DRV_DYN, PAPC_DRV_LOW};

  always_comb
  begin
    rdata_nxt = 32'h0000_0000;
    if (hit_pad)
      rdata_nxt[PAPC_PAD_W-1:0] = pad_r;
    else if (hit_latch)
      rdata_nxt[N-1:0] = latch_r;
    else if (hit_dir)
      rdata_nxt[N-1:0] = dir_r;
    else if (hit_afen)
      rdata_nxt[N-1:0] = afen_r;
    else if (hit_pin)
      rdata_nxt[N-1:0] = pin_rd;
    else if (hit_afin)
      rdata_nxt[N-1:0] = af_din;
    else if (hit_mode)
      rdata_nxt[0] = seg_en_r;
  end

  // no wait state: setup cycle prepares the answer, the first access cycle completes it
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h0000_0000;
    end
    else
    begin
      pready <= setup;
      pslverr <= setup && !mapped;
      prdata <= (setup && !pwrite) ? rdata_nxt : prdata;
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pad_r <= PAPC_PAD_RST;
      latch_r <= '0;
      dir_r <= '0;
      afen_r <= '0;
      seg_en_r <= 1'b0;
    end
    else if (wr_ok && lo_en)
    begin
      if (hit_pad)
      begin
        pad_r[PAPC_SE_LSB +: 2] <= se_w;
        pad_r[PAPC_SD_LSB +: 2] <= sd_w;
        pad_r[PAPC_LE_LSB +: 2] <= le_w;
        pad_r[PAPC_LD_LSB +: 2] <= ld_w;
      end
      if (hit_latch)
        latch_r <= pwdata[N-1:0];
      if (hit_dir)
        dir_r <= pwdata[N-1:0];
      if (hit_afen)
        afen_r <= pwdata[N-1:0];
      if (hit_mode)
        seg_en_r <= pwdata[0];
    end
  end

  // pad outputs only move to legal codes
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      strobe_edge_select <= PAPC_EDGE_FAST;
      strobe_drive_select <= PAPC_DRV_HIGH;
      latch_enable_edge_select <= PAPC_EDGE_FAST;
      latch_enable_drive_select <= PAPC_DRV_HIGH;
    end
    else if (wr_ok && lo_en && hit_pad)
    begin
      if (se_legal)
        strobe_edge_select <= se_w;
      if (sd_legal)
        strobe_drive_select <= sd_w;
      if (le_legal)
        latch_enable_edge_select <= le_w;
      if (ld_legal)
        latch_enable_drive_select <= ld_w;
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      seg_addr_o <= 8'h00;
    else if (seg_en_r)
      seg_addr_o <= bus_addr[PAPC_SEG_LO +: PAPC_SEG_W];
  end

  // each line carries a single alternate function, fixed by the masks
  genvar i;
  generate
    for (i = 0; i < N; i++)
    begin : g_line
      papc_line u_line (
        .pclk(pclk),
        .presetn(presetn),
        .latch_bit(latch_r[i]),
        .dir_bit(dir_r[i]),
        .af_en(afen_r[i]),
        .af_is_out(AF_OUT_MASK[i]),
        .af_auto(AF_AUTO_MASK[i]),
        .af_no_and(AF_PWM_MASK[i]),
        .hw_dir(hw_dir[i]),
        .af_dout(af_dout[i]),
        .pin_in(pin_in[i]),
        .pin_o_r(pin_o[i]),
        .pin_oe_n_r(pin_oe_n[i]),
        .af_din_r(af_din[i]),
        .pin_rd_r(pin_rd[i])
      );
    end
  endgenerate

  property p_pad_low_byte;
    @(posedge pclk) disable iff (!presetn)
    (psel && !penable && !pwrite && hit_pad) |=> prdata[31:PAPC_PAD_W] == 24'h00_0000;
  endproperty
  a_pad_low_byte: assert property (p_pad_low_byte) else $error("pad high bits nonzero");

  property p_edge_legal;
    @(posedge pclk) disable iff (!presetn)
    strobe_edge_select[1] == 1'b0 && latch_enable_edge_select[1] == 1'b0;
  endproperty
  a_edge_legal: assert property (p_edge_legal) else $error("reserved edge code applied");

  property p_drive_legal;
    @(posedge pclk) disable iff (!presetn)
    strobe_drive_select != 2'h3 && latch_enable_drive_select != 2'h3;
  endproperty
  a_drive_legal: assert property (p_drive_legal) else $error("reserved drive code applied");

  property p_pad_write;
    @(posedge pclk) disable iff (!presetn)
    (wr_ok && lo_en && hit_pad && le_legal) |=> latch_enable_edge_select == $past(le_w);
  endproperty
  a_pad_write: assert property (p_pad_write) else $error("latch edge not updated");

  property p_ld_write;
    @(posedge pclk) disable iff (!presetn)
    (wr_ok && lo_en && hit_pad && ld_legal) |=> latch_enable_drive_select == $past(ld_w);
  endproperty
  a_ld_write: assert property (p_ld_write) else $error("latch drive not updated");

  property p_reset_input;
    @(posedge pclk) $rose(presetn) |-> pin_oe_n == {N{1'b1}};
  endproperty
  a_reset_input: assert property (p_reset_input) else $error("line not input after reset");

  property p_and_latch;
    @(posedge pclk) disable iff (!presetn)
    (afen_r[0] && AF_OUT_MASK[0] && !AF_PWM_MASK[0] && !AF_AUTO_MASK[0] && dir_r[0])
      |=> pin_o[0] == ($past(latch_r[0]) & $past(af_dout[0]));
  endproperty
  a_and_latch: assert property (p_and_latch) else $error("alternate output not anded");

  property p_sw_trigger;
    @(posedge pclk) disable iff (!presetn)
    (dir_r[0] && !AF_AUTO_MASK[0] && !(afen_r[0] && AF_OUT_MASK[0]))
      |=> af_din[0] == $past(latch_r[0]) && pin_o[0] == $past(latch_r[0]);
  endproperty
  a_sw_trigger: assert property (p_sw_trigger) else $error("latch not looped to input");

  property p_seg;
    @(posedge pclk) disable iff (!presetn)
    seg_en_r |=> seg_addr_o == $past(bus_addr[23:16]);
  endproperty
  a_seg: assert property (p_seg) else $error("segment address wrong");

  property p_answer;
    @(posedge pclk) disable iff (!presetn)
    (psel && !penable) |=> pready ##1 (!pready || $past(psel && !penable));
  endproperty
  a_answer: assert property (p_answer) else $error("apb answer timing wrong");

  c_pad_wr: cover property (@(posedge pclk) disable iff (!presetn) wr_ok && hit_pad);
  c_err: cover property (@(posedge pclk) disable iff (!presetn) pready && pslverr);
  c_seg: cover property (@(posedge pclk) disable iff (!presetn) seg_en_r);
  c_drive: cover property (@(posedge pclk) disable iff (!presetn) pin_oe_n != {N{1'b1}});
endmodule

/* File: hw/papc_pkg.sv */
// package: register map, field layout and reset values of the port and pad control block
package papc_pkg;
  localparam int PAPC_ADDR_W = 18;
  // the pad register's printed location is a word index; its byte address is four times it
  localparam logic [15:0] PAPC_IDX_PAD = 16'hf0aa;
  localparam logic [PAPC_ADDR_W-1:0] PAPC_OFF_PAD = {PAPC_IDX_PAD, 2'b00};
  localparam logic [PAPC_ADDR_W-1:0] PAPC_OFF_LATCH = 18'h0_0000;
  localparam logic [PAPC_ADDR_W-1:0] PAPC_OFF_DIR = 18'h0_0004;
  localparam logic [PAPC_ADDR_W-1:0] PAPC_OFF_AFEN = 18'h0_0008;
  localparam logic [PAPC_ADDR_W-1:0] PAPC_OFF_PIN = 18'h0_000c;
  localparam logic [PAPC_ADDR_W-1:0] PAPC_OFF_AFIN = 18'h0_0010;
  localparam logic [PAPC_ADDR_W-1:0] PAPC_OFF_MODE = 18'h0_0014;
  localparam int PAPC_SE_LSB = 0;
  localparam int PAPC_SD_LSB = 2;
  localparam int PAPC_LE_LSB = 4;
  localparam int PAPC_LD_LSB = 6;
  localparam int PAPC_PAD_W = 8;
  localparam logic [7:0] PAPC_PAD_RST = 8'h00;
  localparam logic [1:0] PAPC_EDGE_FAST = 2'h0;
  localparam logic [1:0] PAPC_EDGE_SLOW = 2'h1;
  localparam logic [1:0] PAPC_DRV_HIGH = 2'h0;
  localparam logic [1:0] PAPC_DRV_DYN = 2'h1;
  localparam logic [1:0] PAPC_DRV_LOW = 2'h2;
  localparam int PAPC_SEG_LO = 16;
  localparam int PAPC_SEG_W = 8;
endpackage

/* File: hw/papc_line.sv */
// one port line: direction, latch and alternate function combining
module papc_line
  import papc_pkg::*;
(
  input wire logic pclk, // clock
  input wire logic presetn, // async reset, low
  input wire logic latch_bit, // port output latch
  input wire logic dir_bit, // pin_direction_bit, 1 = output
  input wire logic af_en, // alternate function enabled
  input wire logic af_is_out, // alternate function is an output
  input wire logic af_auto, // hardware controls direction
  input wire logic af_no_and, // pulse-width output, bypasses latch and
  input wire logic hw_dir, // hardware direction when automatic
  input wire logic af_dout, // alternate output data
  input wire logic pin_in, // pin level from outside
  output logic pin_o_r, // pin drive value
  output logic pin_oe_n_r, // output enable, low while driving
  output logic af_din_r, // alternate input data
  output logic pin_rd_r // sampled pin level
);
  wire eff_dir = (af_en && af_auto) ? hw_dir : dir_bit;
  wire use_af_out = af_en && af_is_out;
  wire af_val = af_no_and ? af_dout : (latch_bit & af_dout);
  wire drive_val = use_af_out ? af_val : latch_bit;
  // with the driver on, the pin reads back what is driven, so the drive value (the latch, or the alternate output when used) feeds the input
  wire level = eff_dir ? drive_val : pin_in;

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pin_o_r <= 1'b0;
      pin_oe_n_r <= 1'b1;
      af_din_r <= 1'b0;
      pin_rd_r <= 1'b0;
    end
    else
    begin
      pin_o_r <= drive_val;
      pin_oe_n_r <= !eff_dir;
      af_din_r <= level;
      pin_rd_r <= level;
    end
  end

  property p_oe_follows_dir;
    @(posedge pclk) disable iff (!presetn)
    1'b1 |=> pin_oe_n_r == !$past(eff_dir);
  endproperty
  a_oe_follows_dir: assert property (p_oe_follows_dir)
    else $error("pin enable does not follow direction");

  property p_af_gated;
    @(posedge pclk) disable iff (!presetn)
    (use_af_out && !af_no_and && !latch_bit) |=> !pin_o_r;
  endproperty
  a_af_gated: assert property (p_af_gated)
    else $error("alternate output not gated by latch");
endmodule

/* File: tb/papc_pin_dev.sv */
// partner model: outside devices hanging on the port pins
module papc_pin_dev
#(
  parameter int N = 8 // number of pins
)
(
  input wire logic pclk, // clock
  input wire logic [N-1:0] pin_o, // block drive value
  input wire logic [N-1:0] pin_oe_n, // block enable, low drives
  input wire logic [N-1:0] ext_en, // outside device drives the pin
  input wire logic [N-1:0] ext_val, // outside device level
  output logic [N-1:0] pin_in // resolved pin level
);
  timeunit 1ns;
  timeprecision 1ps;
  logic flt_r = 1'b0;
  // undriven pins wander each cycle so a stale level never reads as valid
  always_ff @(posedge pclk)
    flt_r <= ~flt_r;
  // two drivers on one pin give an unknown level
  always_comb
    for (int i = 0; i < N; i++)
      pin_in[i] = (!pin_oe_n[i] && ext_en[i]) ? 1'bx : !pin_oe_n[i] ? pin_o[i] : ext_en[i] ? ext_val[i] : flt_r;
endmodule

/* File: tb/tb_top.sv */
// testbench: apb register traffic and pin checks for the port line block
module tb_top
  import papc_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
  logic [PAPC_ADDR_W-1:0] paddr = '0;
  logic [31:0] pwdata = '0, prdata;
  logic [3:0] pstrb = 4'hf;
  logic pready, pslverr;
  logic [7:0] af_dout = '0, hw_dir = '0, pin_in, pin_o, pin_oe_n, af_din, seg_addr_o;
  logic [7:0] ext_en = '0, ext_val = '0;
  logic [23:0] bus_addr = '0;
  logic [1:0] se, sd, le, ld;
  wire logic [7:0] pads = {ld, le, sd, se};
  int num_errors = 0, checked = 0;
  papc_top #(.N(8), .AF_OUT_MASK(8'h0f), .AF_AUTO_MASK(8'h80), .AF_PWM_MASK(8'h02)) u_dut (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .af_dout(af_dout), .hw_dir(hw_dir), .bus_addr(bus_addr),
    .pin_in(pin_in), .pin_o(pin_o), .pin_oe_n(pin_oe_n), .af_din(af_din),
    .strobe_edge_select(se), .strobe_drive_select(sd), .latch_enable_edge_select(le),
    .latch_enable_drive_select(ld), .seg_addr_o(seg_addr_o));
  papc_pin_dev #(.N(8)) u_dev (.pclk(pclk), .pin_o(pin_o), .pin_oe_n(pin_oe_n),
    .ext_en(ext_en), .ext_val(ext_val), .pin_in(pin_in));
  initial
  begin
    forever #10 pclk = ~pclk;
  end
  task automatic chk(input string nm, input logic [31:0] x, input logic [31:0] g);
    checked++;
    if (g !== x)
    begin
      num_errors++;
      $display("[ERR] %s expected %h seen %h", nm, x, g);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge pclk);
    #1;
  endtask
  task automatic apb(input logic w, input logic [PAPC_ADDR_W-1:0] a, input logic [31:0] d,
                     output logic [31:0] r, output logic e);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do
    begin
      @(posedge pclk);
      n++;
    end
    while (pready !== 1'b1 && n < 50);
    if (n >= 50)
      chk("pready", 1, 0);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wr(input logic [PAPC_ADDR_W-1:0] a, input logic [31:0] d);
    logic [31:0] r;
    logic e;
    apb(1'b1, a, d, r, e);
    cyc(2);
  endtask
  task automatic rd(input logic [PAPC_ADDR_W-1:0] a, input logic [31:0] x, input string nm);
    logic [31:0] r;
    logic e;
    apb(1'b0, a, 32'h0000_0000, r, e);
    chk(nm, x, r);
  endtask
  task automatic t_reset();
    rd(PAPC_OFF_PAD, 32'h0000_0000, "pad_rst");
    rd(PAPC_OFF_DIR, 32'h0000_0000, "dir_rst");
    chk("oe_rst", 8'hff, pin_oe_n);
    $display("reset test done");
  endtask
  task automatic t_pad();
    logic [1:0] ex;
    ex = 2'h0;
    for (int f = 0; f < 4; f++)
      for (int c = 0; c < 4; c++)
      begin
        if (c <= ((f % 2) ? 2 : 1))
          ex = c[1:0];
        wr(PAPC_OFF_PAD, 32'(c) << (2 * f));
        rd(PAPC_OFF_PAD, 32'(c) << (2 * f), "pad_rb");
        chk("pad_out", 32'(ex) << (2 * f), 32'(pads));
      end
    wr(PAPC_OFF_PAD, 32'h0000_ffff);
    rd(PAPC_OFF_PAD, 32'h0000_00ff, "pad_hi");
    $display("pad test done");
  endtask
  task automatic t_altout();
    wr(PAPC_OFF_LATCH, 32'h0000_0003);
    wr(PAPC_OFF_DIR, 32'h0000_0000);
    wr(PAPC_OFF_AFEN, 32'h0000_0003);
    rd(PAPC_OFF_LATCH, 32'h0000_0003, "latch_rb");
    rd(PAPC_OFF_AFEN, 32'h0000_0003, "afen_rb");
    @(posedge pclk);
    af_dout <= 8'h03;
    cyc(3);
    chk("oe_dir0", 2'b11, pin_oe_n[1:0]);
    wr(PAPC_OFF_DIR, 32'h0000_0003);
    chk("oe_dir1", 2'b00, pin_oe_n[1:0]);
    chk("and_11", 2'b11, pin_o[1:0]);
    wr(PAPC_OFF_LATCH, 32'h0000_0000);
    chk("and_l0", 2'b10, pin_o[1:0]);
    @(posedge pclk);
    af_dout <= 8'h00;
    cyc(3);
    chk("and_d0", 2'b00, pin_o[1:0]);
    $display("alternate output test done");
  endtask
  task automatic t_altin();
    wr(PAPC_OFF_DIR, 32'h0000_0000);
    wr(PAPC_OFF_AFEN, 32'h0000_0010);
    @(posedge pclk);
    ext_en <= 8'hff;
    ext_val <= 8'h10;
    cyc(3);
    chk("afin_ext1", 1, af_din[4]);
    rd(PAPC_OFF_PIN, 32'h0000_0010, "pin_rd");
    rd(PAPC_OFF_AFIN, 32'h0000_0010, "afin_rd");
    @(posedge pclk);
    ext_val <= 8'h00;
    cyc(3);
    chk("afin_ext0", 0, af_din[4]);
    @(posedge pclk);
    ext_en <= 8'h00;
    rd(PAPC_OFF_MODE, 32'h0000_0000, "mode_sep");
    wr(PAPC_OFF_LATCH, 32'h0000_0010);
    wr(PAPC_OFF_DIR, 32'h0000_0010);
    chk("in_oe", 0, pin_oe_n[4]);
    chk("in_pin1", 1, pin_o[4]);
    chk("in_afin1", 1, af_din[4]);
    wr(PAPC_OFF_LATCH, 32'h0000_0000);
    chk("in_pin0", 0, pin_o[4]);
    chk("in_afin0", 0, af_din[4]);
    $display("alternate input test done");
  endtask
  task automatic t_auto();
    wr(PAPC_OFF_DIR, 32'h0000_0000);
    wr(PAPC_OFF_AFEN, 32'h0000_0080);
    for (int k = 0; k < 4; k++)
    begin
      @(posedge pclk);
      hw_dir <= {k[0], 7'h00};
      cyc(3);
      chk("auto_oe", !k[0], pin_oe_n[7]);
    end
    $display("automatic direction test done");
  endtask
  task automatic t_seg_err();
    logic [31:0] r;
    logic e;
    wr(PAPC_OFF_MODE, 32'h0000_0001);
    @(posedge pclk);
    bus_addr <= 24'h5a_1234;
    cyc(3);
    chk("seg", 8'h5a, seg_addr_o);
    apb(1'b1, 18'h0_0020, 32'h0000_ffff, r, e);
    chk("err_wr", 1, e);
    apb(1'b0, 18'h0_0020, 32'h0000_0000, r, e);
    chk("err_rd", 1, e);
    chk("err_data", 32'h0000_0000, r);
    $display("segment and error test done");
  endtask
  task automatic end_of_test();
    $display("comparisons %0d mismatches %0d", checked, num_errors);
    if (num_errors == 0 && checked > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  initial
  begin
    #400000;
    num_errors++;
    end_of_test();
  end
  initial
  begin
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    t_reset();
    t_pad();
    t_altout();
    t_altin();
    t_auto();
    t_seg_err();
    end_of_test();
  end
endmodule
